// file: logic/bus_port.sv
// Bus cycle engine: one read or write cycle per request.
`timescale 1ns/1ps
`default_nettype none
module bus_port #(
  parameter int AW = 20,
  parameter int DW = 16
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Request side.
  input wire logic req,
  input wire logic req_write,
  input wire logic req_io,
  input wire logic req_byte,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic done,
  output logic [DW-1:0] rdata,
  // Bus side.
  output logic bus_req,
  output logic bus_write,
  output logic bus_io,
  output logic bus_byte,
  output logic [AW-1:0] bus_addr,
  output logic [DW-1:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [DW-1:0] bus_rdata
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_req <= 1'b0;
      bus_write <= 1'b0;
      bus_io <= 1'b0;
      bus_byte <= 1'b0;
      bus_addr <= '0;
      bus_wdata <= '0;
    end
    else if (bus_req)
    begin
      if (bus_ack)
        bus_req <= 1'b0;
    end
    else if (req && !done)
    begin
      bus_req <= 1'b1;
      bus_write <= req_write;
      bus_io <= req_io;
      bus_byte <= req_byte;
      bus_addr <= req_addr;
      bus_wdata <= req_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      done <= bus_req && bus_ack;
      if (bus_req && bus_ack)
        rdata <= bus_rdata;
    end
  end
endmodule
`default_nettype wire

// file: logic/frame_ops.sv
// Sequencer for save/restore-all, string I/O, frame and range check ops.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RL1] Save-all pushes eight registers in order.
// [RL2] Saved stack pointer is pre-push value.
// [RL3] Restore-all pops all; stack pointer word discarded.
// [RL4] No segment, pointer, status, peripheral saves.
// [RL5] String input: port to extra segment.
// [RL6] Pointer steps by size, direction sets sign.
// [RL7] String output: data segment, overridable.
// [RL8] Frame create takes size and level.
// [RL9] Level zero: push, copy, subtract.
// [RL10] Nested level copies display pointers.
// [RL11] Release: stack from base, pop base.
// [RL12] Out of range raises exception five.
// [RL13] Lower limit at address, upper next.
// [RL14] Register limit operand: invalid opcode.
// [RL15] Value equal to limit is inside.
module frame_ops
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Instruction issue.
  input wire logic start,
  input wire logic [2:0] opcode,
  input wire logic byte_op,
  input wire logic direction_flag,
  input wire logic seg_override,
  input wire logic [15:0] override_seg,
  input wire logic [15:0] frame_size,
  input wire logic [7:0] frame_level,
  input wire logic [2:0] check_reg,
  input wire logic limit_is_reg,
  input wire logic [15:0] limit_ea,
  // Segment registers, read only.
  input wire logic [15:0] extra_segment,
  input wire logic [15:0] data_segment,
  input wire logic [15:0] stack_segment,
  // Register file load and view.
  input wire logic reg_load,
  input wire logic [2:0] reg_load_sel,
  input wire logic [15:0] reg_load_data,
  output logic [127:0] regs_out,
  // Completion.
  output logic busy,
  output logic op_done,
  output logic exc_valid,
  output logic [7:0] exc_vector,
  // Local bus.
  output logic bus_req,
  output logic bus_write,
  output logic bus_io,
  output logic bus_byte,
  output logic [19:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata
);
  localparam int W = frame_ops_pkg::WORD_W;
  localparam int AW = frame_ops_pkg::ADDR_W;

  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  function automatic logic [AW-1:0] phys(input logic [W-1:0] seg,
                                         input logic [W-1:0] off);
    phys = AW'({seg, 4'h0}) + AW'(off);
  endfunction

  logic [W-1:0] regs_r [frame_ops_pkg::REG_N];
  frame_ops_pkg::state_e state_r;
  frame_ops_pkg::op_e op_r;
  logic [2:0] idx_r;
  logic [W-1:0] temp_r;
  logic [W-1:0] orig_sp_r;
  logic [W-1:0] lower_r;
  logic [7:0] count_r;
  logic [W-1:0] data_r;
  logic byte_r;
  logic dir_r;
  logic [W-1:0] str_seg_r;

  logic req;
  logic req_write;
  logic req_io;
  logic [AW-1:0] req_addr;
  logic [W-1:0] req_wdata;
  logic done;
  logic [W-1:0] rdata;
  logic [W-1:0] sp;
  logic [W-1:0] sp_dec;
  logic [W-1:0] step;
  logic signed [W-1:0] chk_val;

  assign sp = regs_r[frame_ops_pkg::REG_SP];
  assign sp_dec = sp - frame_ops_pkg::STEP_WORD;
  // [RL6] Step size selection.
  assign step = byte_r ? frame_ops_pkg::STEP_BYTE : frame_ops_pkg::STEP_WORD;
  assign chk_val = regs_r[check_reg];

  bus_port #(.AW(AW), .DW(W)) u_bus
  (
    .clk(clk),
    .rst_n(rst_n_r),
    .req(req),
    .req_write(req_write),
    .req_io(req_io),
    .req_byte(byte_r),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .done(done),
    .rdata(rdata),
    .bus_req(bus_req),
    .bus_write(bus_write),
    .bus_io(bus_io),
    .bus_byte(bus_byte),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_ack(bus_ack),
    .bus_rdata(bus_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus request decode.
  always_comb
  begin
    req = 1'b1;
    req_write = 1'b1;
    req_io = 1'b0;
    req_addr = phys(stack_segment, sp_dec);
    req_wdata = regs_r[idx_r];
    unique case (state_r)
      frame_ops_pkg::ST_SAVE:
      begin
        // [RL2] Saved stack pointer value.
        if (idx_r == frame_ops_pkg::REG_SP)
          req_wdata = orig_sp_r;
      end
      frame_ops_pkg::ST_RESTORE, frame_ops_pkg::ST_FR_POP:
      begin
        req_write = 1'b0;
        req_addr = phys(stack_segment, sp);
      end
      frame_ops_pkg::ST_STR_RD:
      begin
        req_write = 1'b0;
        req_io = (op_r == frame_ops_pkg::OP_STR_IN);
        // [RL5] [RL7] Source of the string transfer.
        req_addr = req_io ? AW'(regs_r[frame_ops_pkg::REG_PORT])
                          : phys(str_seg_r, regs_r[frame_ops_pkg::REG_SRC]);
      end
      frame_ops_pkg::ST_STR_WR:
      begin
        req_io = (op_r == frame_ops_pkg::OP_STR_OUT);
        req_wdata = data_r;
        req_addr = req_io ? AW'(regs_r[frame_ops_pkg::REG_PORT])
                          : phys(extra_segment, regs_r[frame_ops_pkg::REG_DST]);
      end
      frame_ops_pkg::ST_FC_PUSH:
        req_wdata = regs_r[frame_ops_pkg::REG_FBP];
      frame_ops_pkg::ST_FC_COPY_RD:
      begin
        req_write = 1'b0;
        req_addr = phys(stack_segment,
                        regs_r[frame_ops_pkg::REG_FBP] - frame_ops_pkg::STEP_WORD);
      end
      frame_ops_pkg::ST_FC_COPY_WR:
        req_wdata = data_r;
      frame_ops_pkg::ST_FC_TEMP:
        req_wdata = temp_r;
      frame_ops_pkg::ST_RC_LO, frame_ops_pkg::ST_RC_HI:
      begin
        req_write = 1'b0;
        // [RL13] Lower then upper limit word.
        req_addr = phys(data_segment, (state_r == frame_ops_pkg::ST_RC_HI)
                        ? limit_ea + frame_ops_pkg::STEP_WORD : limit_ea);
      end
      default:
        req = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= frame_ops_pkg::ST_IDLE;
      op_r <= frame_ops_pkg::OP_NONE;
      idx_r <= '0;
      temp_r <= '0;
      orig_sp_r <= '0;
      lower_r <= '0;
      count_r <= '0;
      data_r <= '0;
      byte_r <= 1'b0;
      dir_r <= 1'b0;
      str_seg_r <= '0;
      busy <= 1'b0;
      op_done <= 1'b0;
      exc_valid <= 1'b0;
      exc_vector <= '0;
      for (int i = 0; i < frame_ops_pkg::REG_N; i++)
        regs_r[i] <= '0;
    end
    else
    begin
      op_done <= 1'b0;
      exc_valid <= 1'b0;
      if (reg_load && state_r == frame_ops_pkg::ST_IDLE)
        regs_r[reg_load_sel] <= reg_load_data;
      unique case (state_r)
        frame_ops_pkg::ST_IDLE:
        begin
          if (start)
          begin
            busy <= 1'b1;
            op_r <= frame_ops_pkg::op_e'(opcode);
            byte_r <= byte_op;
            dir_r <= direction_flag;
            idx_r <= frame_ops_pkg::REG_ACC;
            orig_sp_r <= sp;
            // [RL7] Override allowed for output only.
            str_seg_r <= seg_override ? override_seg : data_segment;
            count_r <= frame_level;
            unique case (frame_ops_pkg::op_e'(opcode))
              // [RL1] [RL4] Only general registers saved.
              frame_ops_pkg::OP_SAVE_ALL:
                state_r <= frame_ops_pkg::ST_SAVE;
              frame_ops_pkg::OP_RESTORE_ALL:
              begin
                idx_r <= frame_ops_pkg::REG_LAST;
                state_r <= frame_ops_pkg::ST_RESTORE;
              end
              frame_ops_pkg::OP_STR_IN, frame_ops_pkg::OP_STR_OUT:
                state_r <= frame_ops_pkg::ST_STR_RD;
              // [RL8] Level captured at start; size read live from frame_size.
              frame_ops_pkg::OP_FRAME_CREATE:
                state_r <= frame_ops_pkg::ST_FC_PUSH;
              frame_ops_pkg::OP_FRAME_RELEASE:
              begin
                // [RL11] Stack pointer from frame base.
                regs_r[frame_ops_pkg::REG_SP] <= regs_r[frame_ops_pkg::REG_FBP];
                state_r <= frame_ops_pkg::ST_FR_POP;
              end
              frame_ops_pkg::OP_RANGE_CHECK:
              begin
                // [RL14] Register limits invalid.
                if (limit_is_reg)
                begin
                  exc_valid <= 1'b1;
                  exc_vector <= frame_ops_pkg::VEC_BAD_OP;
                  state_r <= frame_ops_pkg::ST_DONE;
                end
                else
                  state_r <= frame_ops_pkg::ST_RC_LO;
              end
              default:
                state_r <= frame_ops_pkg::ST_DONE;
            endcase
          end
        end
        frame_ops_pkg::ST_SAVE:
          if (done)
          begin
            regs_r[frame_ops_pkg::REG_SP] <= sp_dec;
            idx_r <= idx_r + 3'h1;
            if (idx_r == frame_ops_pkg::REG_LAST)
              state_r <= frame_ops_pkg::ST_DONE;
          end
        frame_ops_pkg::ST_RESTORE:
          if (done)
          begin
            // [RL3] Popped stack pointer discarded.
            if (idx_r != frame_ops_pkg::REG_SP)
              regs_r[idx_r] <= rdata;
            regs_r[frame_ops_pkg::REG_SP] <= sp + frame_ops_pkg::STEP_WORD;
            idx_r <= idx_r - 3'h1;
            if (idx_r == frame_ops_pkg::REG_ACC)
              state_r <= frame_ops_pkg::ST_DONE;
          end
        frame_ops_pkg::ST_STR_RD:
          if (done)
          begin
            data_r <= rdata;
            state_r <= frame_ops_pkg::ST_STR_WR;
          end
        frame_ops_pkg::ST_STR_WR:
          if (done)
          begin
            // [RL6] Pointer update after transfer.
            if (op_r == frame_ops_pkg::OP_STR_IN)
              regs_r[frame_ops_pkg::REG_DST] <= dir_r
                ? regs_r[frame_ops_pkg::REG_DST] - step
                : regs_r[frame_ops_pkg::REG_DST] + step;
            else
              regs_r[frame_ops_pkg::REG_SRC] <= dir_r
                ? regs_r[frame_ops_pkg::REG_SRC] - step
                : regs_r[frame_ops_pkg::REG_SRC] + step;
            state_r <= frame_ops_pkg::ST_DONE;
          end
        frame_ops_pkg::ST_FC_PUSH:
          if (done)
          begin
            regs_r[frame_ops_pkg::REG_SP] <= sp_dec;
            temp_r <= sp_dec;
            // [RL9] Level zero copies and allocates.
            if (count_r == frame_ops_pkg::LEVEL_ZERO)
            begin
              regs_r[frame_ops_pkg::REG_FBP] <= sp_dec;
              regs_r[frame_ops_pkg::REG_SP] <= sp_dec - frame_size;
              state_r <= frame_ops_pkg::ST_DONE;
            end
            // [RL10] Nested form copies display.
            else if (count_r == frame_ops_pkg::LEVEL_ONE)
              state_r <= frame_ops_pkg::ST_FC_TEMP;
            else
              state_r <= frame_ops_pkg::ST_FC_COPY_RD;
          end
        frame_ops_pkg::ST_FC_COPY_RD:
          if (done)
          begin
            data_r <= rdata;
            regs_r[frame_ops_pkg::REG_FBP] <=
              regs_r[frame_ops_pkg::REG_FBP] - frame_ops_pkg::STEP_WORD;
            count_r <= count_r - 8'h01;
            state_r <= frame_ops_pkg::ST_FC_COPY_WR;
          end
        frame_ops_pkg::ST_FC_COPY_WR:
          if (done)
          begin
            regs_r[frame_ops_pkg::REG_SP] <= sp_dec;
            state_r <= (count_r == frame_ops_pkg::LEVEL_ONE)
                       ? frame_ops_pkg::ST_FC_TEMP
                       : frame_ops_pkg::ST_FC_COPY_RD;
          end
        frame_ops_pkg::ST_FC_TEMP:
          if (done)
          begin
            regs_r[frame_ops_pkg::REG_FBP] <= temp_r;
            regs_r[frame_ops_pkg::REG_SP] <= sp_dec - frame_size;
            state_r <= frame_ops_pkg::ST_DONE;
          end
        frame_ops_pkg::ST_FR_POP:
          if (done)
          begin
            regs_r[frame_ops_pkg::REG_FBP] <= rdata;
            regs_r[frame_ops_pkg::REG_SP] <= sp + frame_ops_pkg::STEP_WORD;
            state_r <= frame_ops_pkg::ST_DONE;
          end
        frame_ops_pkg::ST_RC_LO:
          if (done)
          begin
            lower_r <= rdata;
            state_r <= frame_ops_pkg::ST_RC_HI;
          end
        frame_ops_pkg::ST_RC_HI:
          if (done)
          begin
            // [RL12] [RL15] Inclusive signed bounds.
            if (chk_val < $signed(lower_r) || chk_val > $signed(rdata))
            begin
              exc_valid <= 1'b1;
              exc_vector <= frame_ops_pkg::VEC_BOUNDS;
            end
            state_r <= frame_ops_pkg::ST_DONE;
          end
        frame_ops_pkg::ST_DONE:
        begin
          busy <= 1'b0;
          op_done <= 1'b1;
          state_r <= frame_ops_pkg::ST_IDLE;
        end
        default:
          state_r <= frame_ops_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      regs_out <= '0;
    else
      for (int i = 0; i < frame_ops_pkg::REG_N; i++)
        regs_out[i*W +: W] <= regs_r[i];
  end
endmodule
`default_nettype wire

// file: logic/frame_ops_pkg.sv
// Package with constants and types for the stack, string and frame unit.
`default_nettype none
package frame_ops_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 20;
  localparam int REG_N = 8;
  // General register indices, in save order.
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_CNT = 3'h1;
  localparam logic [2:0] REG_PORT = 3'h2;
  localparam logic [2:0] REG_BASE = 3'h3;
  localparam logic [2:0] REG_SP = 3'h4;
  localparam logic [2:0] REG_FBP = 3'h5;
  localparam logic [2:0] REG_SRC = 3'h6;
  localparam logic [2:0] REG_DST = 3'h7;
  localparam logic [2:0] REG_LAST = 3'h7;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [3:0] SEG_SHIFT = 4'h4;
  localparam logic [7:0] VEC_BOUNDS = 8'h05;
  localparam logic [7:0] VEC_BAD_OP = 8'h06;
  localparam logic [7:0] LEVEL_ZERO = 8'h00;
  localparam logic [7:0] LEVEL_ONE = 8'h01;
  typedef enum logic [2:0]
  {
    OP_SAVE_ALL = 3'h0,
    OP_RESTORE_ALL = 3'h1,
    OP_STR_IN = 3'h2,
    OP_STR_OUT = 3'h3,
    OP_FRAME_CREATE = 3'h4,
    OP_FRAME_RELEASE = 3'h5,
    OP_RANGE_CHECK = 3'h6,
    OP_NONE = 3'h7
  } op_e;
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h0,
    ST_SAVE = 4'h1,
    ST_RESTORE = 4'h2,
    ST_STR_RD = 4'h3,
    ST_STR_WR = 4'h4,
    ST_FC_PUSH = 4'h5,
    ST_FC_COPY_RD = 4'h6,
    ST_FC_COPY_WR = 4'h7,
    ST_FC_TEMP = 4'h8,
    ST_FR_POP = 4'h9,
    ST_RC_LO = 4'ha,
    ST_RC_HI = 4'hb,
    ST_DONE = 4'hc
  } state_e;
endpackage
`default_nettype wire

// file: tb/bus_partner.sv
// Behavioural memory and I/O devices on the local bus.
`timescale 1ns/1ps
`default_nettype none
module bus_partner
(
  // Clock.
  input wire logic clk,
  // Local bus.
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_io,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic bus_ack,
  output logic [15:0] bus_rdata,
  // Wait states per cycle.
  input wire logic [3:0] lat
);
  logic [15:0] mem [int];
  logic [20:0] wa [$];
  logic [15:0] wd [$];
  logic [3:0] cnt = 4'h0;
  initial bus_ack = 1'b0;
  initial bus_rdata = 16'h0000;
  // Read data toggles every cycle except when a read is answered.
  always @(posedge clk)
  begin
    bus_rdata <= ~bus_rdata;
    if (bus_ack)
    begin
      bus_ack <= 1'b0;
      cnt <= 4'h0;
    end
    else if (bus_req && cnt < lat)
      cnt <= cnt + 4'h1;
    else if (bus_req)
    begin
      bus_ack <= 1'b1;
      if (bus_write)
      begin
        wa.push_back({bus_io, bus_addr});
        wd.push_back(bus_wdata);
        if (!bus_io)
          mem[int'(bus_addr)] = bus_wdata;
      end
      else if (bus_io)
        bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
      else
        bus_rdata <= mem.exists(int'(bus_addr)) ? mem[int'(bus_addr)] : 16'h0;
    end
  end
endmodule
`default_nettype wire

// file: tb/frame_ops_checker.sv
// Assertions on the bus cycles and exceptions of the frame unit.
`timescale 1ns/1ps
`default_nettype none
module frame_ops_checker
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Issue.
  input wire logic start,
  input wire logic [2:0] opcode,
  input wire logic seg_override,
  input wire logic [15:0] override_seg,
  input wire logic [2:0] check_reg,
  input wire logic limit_is_reg,
  input wire logic [15:0] limit_ea,
  input wire logic [15:0] extra_segment,
  input wire logic [15:0] data_segment,
  input wire logic [15:0] stack_segment,
  input wire logic [127:0] regs_out,
  // Completion.
  input wire logic busy,
  input wire logic op_done,
  input wire logic exc_valid,
  input wire logic [7:0] exc_vector,
  // Local bus.
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_io,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] op_r;
  logic lir_r, exc_r, out;
  logic [3:0] n_r;
  logic [127:0] rg_r;
  logic [15:0] lo_r, hi_r, val, sp0, nb;
  logic [19:0] ss_b, os_b;
  assign val = rg_r[{check_reg, 4'h0} +: 16];
  assign sp0 = rg_r[79:64];
  assign nb = {11'h0, n_r, 1'b0};
  assign ss_b = {stack_segment, 4'h0};
  assign os_b = {seg_override ? override_seg : data_segment, 4'h0};
  assign out = $signed(val) < $signed(lo_r) || $signed(val) > $signed(hi_r);
  ////////////////////////////////////////////////////////////////////////////
  // Captures the operation, its registers and the limits it fetched.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_r <= frame_ops_pkg::OP_NONE;
      lir_r <= 1'b0;
      exc_r <= 1'b0;
      n_r <= 4'h0;
      rg_r <= '0;
      lo_r <= 16'h0;
      hi_r <= 16'h0;
    end
    else if (start && !busy && !op_done)
    begin
      op_r <= opcode;
      lir_r <= limit_is_reg;
      exc_r <= 1'b0;
      n_r <= 4'h0;
      rg_r <= regs_out;
    end
    else
    begin
      if (exc_valid)
        exc_r <= 1'b1;
      if (bus_req && bus_ack)
        n_r <= n_r + 4'h1;
      if (bus_req && bus_ack && n_r == 4'h0)
        lo_r <= bus_rdata;
      if (bus_req && bus_ack && n_r == 4'h1)
        hi_r <= bus_rdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  save_order_a: assert property (
    op_r == frame_ops_pkg::OP_SAVE_ALL && bus_req |-> n_r < 4'h8 && bus_write
    && bus_addr == ss_b + {4'h0, sp0 - nb - 16'h2}
    && bus_wdata == rg_r[{n_r[2:0], 4'h0} +: 16])
    else $error("push wrong");
  restore_order_a: assert property (
    op_r == frame_ops_pkg::OP_RESTORE_ALL && bus_req |-> n_r < 4'h8
    && !bus_write && bus_addr == ss_b + {4'h0, sp0 + nb})
    else $error("pop wrong");
  str_in_a: assert property (
    op_r == frame_ops_pkg::OP_STR_IN && bus_req |-> (n_r == 4'h0)
    ? (bus_io && !bus_write && bus_addr == {4'h0, rg_r[47:32]})
    : (!bus_io && bus_write
    && bus_addr == {extra_segment, 4'h0} + {4'h0, rg_r[127:112]}))
    else $error("input wrong");
  str_out_a: assert property (
    op_r == frame_ops_pkg::OP_STR_OUT && bus_req |-> (n_r == 4'h0)
    ? (!bus_io && !bus_write && bus_addr == os_b + {4'h0, rg_r[111:96]})
    : (bus_io && bus_write && bus_addr == {4'h0, rg_r[47:32]}))
    else $error("output wrong");
  fc_first_a: assert property (
    op_r == frame_ops_pkg::OP_FRAME_CREATE && bus_req && n_r == 4'h0
    |-> bus_write && bus_addr == ss_b + {4'h0, sp0 - 16'h2}
    && bus_wdata == rg_r[95:80])
    else $error("frame push wrong");
  frame_release_pop_a: assert property (
    op_r == frame_ops_pkg::OP_FRAME_RELEASE && bus_req |-> !bus_write
    && !bus_io && bus_addr == ss_b + {4'h0, rg_r[95:80]})
    else $error("release wrong");
  bound_addr_a: assert property (
    op_r == frame_ops_pkg::OP_RANGE_CHECK && bus_req |-> !lir_r && !bus_write
    && bus_addr == {data_segment, 4'h0} + {4'h0, limit_ea + nb})
    else $error("limit fetch wrong");
  bound_raise_a: assert property (
    op_r == frame_ops_pkg::OP_RANGE_CHECK && !lir_r && n_r == 4'h2 && out
    && !exc_r |-> ##[0:4] exc_valid)
    else $error("bounds missed");
  bound_quiet_a: assert property (
    exc_valid && op_r == frame_ops_pkg::OP_RANGE_CHECK && !lir_r |-> out
    && exc_vector == frame_ops_pkg::VEC_BOUNDS)
    else $error("bounds wrong");
  bad_limit_a: assert property (
    start && !busy && !op_done && opcode == frame_ops_pkg::OP_RANGE_CHECK
    && limit_is_reg |-> ##[1:3] exc_valid
    && exc_vector == frame_ops_pkg::VEC_BAD_OP)
    else $error("limit not refused");
  bus_hold_a: assert property (
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
    && $stable(bus_wdata) && $stable(bus_write))
    else $error("request unstable");
endmodule
bind frame_ops frame_ops_checker chk_i (.*);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the stack, string and frame unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, reset_n = 1'b0, start = 1'b0, byte_op = 1'b0;
  logic direction_flag = 1'b0, seg_override = 1'b0, limit_is_reg = 1'b0;
  logic reg_load = 1'b0;
  logic [2:0] opcode = 3'h7, check_reg = 3'h1, reg_load_sel = 3'h0;
  logic [15:0] override_seg = 16'h3000, frame_size = 16'h0;
  logic [15:0] limit_ea = 16'h0100, extra_segment = 16'h2000;
  logic [15:0] data_segment = 16'h1000, stack_segment = 16'h4000;
  logic [15:0] reg_load_data = 16'h0;
  logic [7:0] frame_level = 8'h0, exc_vector, last_vec = 8'h0;
  logic [3:0] lat = 4'h0;
  logic [127:0] regs_out;
  logic busy, op_done, exc_valid, bus_req, bus_write, bus_io, bus_byte;
  logic bus_ack;
  logic [19:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  int n_fail = 0, checks = 0, n_exc = 0, cyc = 0;
  frame_ops dut (.*);
  bus_partner dev (.*);
  initial forever #4 clk = ~clk;
  always @(negedge clk)
  begin
    cyc++;
    if (exc_valid === 1'b1)
    begin
      n_exc++;
      last_vec = exc_vector;
    end
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rg(input int i);
    return regs_out[16 * i +: 16];
  endfunction
  function automatic logic [19:0] pa(input logic [15:0] s, o);
    return {s, 4'h0} + {4'h0, o};
  endfunction
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic setr(input logic [2:0] i, input logic [15:0] v);
    @(negedge clk);
    reg_load = 1'b1;
    reg_load_sel = i;
    reg_load_data = v;
    @(negedge clk);
    reg_load = 1'b0;
  endtask
  task automatic run(input logic [2:0] op);
    int k;
    dev.wa.delete();
    dev.wd.delete();
    @(negedge clk);
    opcode = op;
    start = 1'b1;
    for (k = 0; k < 300; k++)
    begin
      @(negedge clk);
      start = 1'b0;
      if (op_done === 1'b1)
        break;
    end
    chk(21'(k < 300), 21'h1);
    repeat (3) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_save_restore();
    logic [15:0] v [8];
    lat = 4'h3;
    for (int i = 0; i < 8; i++)
    begin
      v[i] = (i == 4) ? 16'h0200 : 16'ha001 + 16'(i) * 16'h1111;
      setr(3'(i), v[i]);
    end
    run(frame_ops_pkg::OP_SAVE_ALL);
    chk(21'(dev.wa.size()), 21'h8);
    for (int i = 0; i < 8; i++)
    begin
      chk(dev.wa[i], {1'b0, pa(stack_segment, 16'h01fe - 16'(2 * i))});
      chk(21'(dev.wd[i]), 21'(v[i]));
    end
    chk(21'(rg(4)), 21'h1f0);
    dev.mem[int'(pa(stack_segment, 16'h01f6))] = 16'h7777;
    for (int i = 0; i < 8; i++)
      if (i != 4)
        setr(3'(i), 16'h0);
    run(frame_ops_pkg::OP_RESTORE_ALL);
    for (int i = 0; i < 8; i++)
      chk(21'(rg(i)), 21'(v[i]));
    lat = 4'h1;
  endtask
  task automatic t_string();
    logic [15:0] st, m, e;
    for (int c = 0; c < 4; c++)
    begin
      byte_op = c[0];
      direction_flag = c[1];
      seg_override = c[0] ^ c[1];
      st = c[0] ? 16'h1 : 16'h2;
      m = c[0] ? 16'h00ff : 16'hffff;
      setr(3'h2, 16'h0054);
      setr(3'h7, 16'h0300);
      setr(3'h6, 16'h0400);
      run(frame_ops_pkg::OP_STR_IN);
      chk(dev.wa[0], {1'b0, pa(extra_segment, 16'h0300)});
      chk(21'(dev.wd[0] & m), 21'(16'h5a0e & m));
      e = c[1] ? 16'h0300 - st : 16'h0300 + st;
      chk(21'(rg(7)), 21'(e));
      e = seg_override ? override_seg : data_segment;
      dev.mem[int'(pa(e, 16'h0400))] = 16'h1234 + 16'(c);
      run(frame_ops_pkg::OP_STR_OUT);
      chk(dev.wa[0], 21'h100054);
      chk(21'(dev.wd[0] & m), 21'((16'h1234 + 16'(c)) & m));
      e = c[1] ? 16'h0400 - st : 16'h0400 + st;
      chk(21'(rg(6)), 21'(e));
    end
    lat = 4'h0;
  endtask
  task automatic t_frame();
    logic [15:0] w [4];
    w = '{16'h0600, 16'h0abc, 16'h0def, 16'h04fe};
    setr(3'h4, 16'h0500);
    setr(3'h5, 16'h0600);
    frame_size = 16'h0010;
    run(frame_ops_pkg::OP_FRAME_CREATE);
    chk(21'(dev.wa.size()), 21'h1);
    chk(21'(dev.wd[0]), 21'h600);
    chk(21'(rg(5)), 21'h4fe);
    chk(21'(rg(4)), 21'h4ee);
    setr(3'h4, 16'h0500);
    setr(3'h5, 16'h0600);
    dev.mem[int'(pa(stack_segment, 16'h05fe))] = w[1];
    dev.mem[int'(pa(stack_segment, 16'h05fc))] = w[2];
    frame_size = 16'h8100;
    frame_level = 8'h03;
    run(frame_ops_pkg::OP_FRAME_CREATE);
    chk(21'(dev.wa.size()), 21'h4);
    for (int i = 0; i < 4; i++)
    begin
      chk(dev.wa[i], {1'b0, pa(stack_segment, 16'h04fe - 16'(2 * i))});
      chk(21'(dev.wd[i]), 21'(w[i]));
    end
    chk(21'(rg(5)), 21'h4fe);
    chk(21'(rg(4)), 21'h83f8);
    run(frame_ops_pkg::OP_FRAME_RELEASE);
    chk(21'(rg(4)), 21'h500);
    chk(21'(rg(5)), 21'h600);
  endtask
  task automatic t_bound();
    logic [15:0] v [5];
    logic [4:0] o;
    v = '{16'hfffc, 16'hfffd, 16'h0005, 16'h0006, 16'h0000};
    o = 5'b01001;
    dev.mem[int'(pa(data_segment, limit_ea))] = 16'hfffd;
    dev.mem[int'(pa(data_segment, limit_ea + 16'h2))] = 16'h0005;
    for (int i = 0; i < 6; i++)
    begin
      limit_is_reg = (i == 5);
      if (i < 5)
        setr(check_reg, v[i]);
      n_exc = 0;
      last_vec = 8'h0;
      run(frame_ops_pkg::OP_RANGE_CHECK);
      if (i < 5)
      begin
        chk(21'(n_exc), 21'(o[i]));
        chk(21'(last_vec), 21'(o[i] ? 8'h05 : 8'h00));
      end
      else
      begin
        chk(21'(n_exc), 21'h1);
        chk(21'(last_vec), 21'h6);
      end
    end
    limit_is_reg = 1'b0;
  endtask
  task automatic end_sim();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_save_restore();
    t_string();
    t_frame();
    t_bound();
    end_sim();
  end
endmodule
`default_nettype wire
